// ### include/chg_seq_pkg.sv
// Package with constants, states and carriers of the charge sequencer.
package chg_seq_pkg;

  localparam int unsigned CLK_FREQ_HZ     = 125_000_000;
  localparam int unsigned TICK_PERIOD_US  = 1000;
  localparam int unsigned TICK_CYCLES     =
    (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;
  localparam int unsigned DET_TIME_MS     = 250;
  localparam int unsigned DET_TICKS       = DET_TIME_MS;
  localparam int unsigned TMR_W           = 24;

  // Termination fraction select codes, named for their percent of fast current.
  localparam logic [1:0] TERM_SEL_2P5     = 2'h0;
  localparam logic [1:0] TERM_SEL_7P5     = 2'h1;
  localparam logic [1:0] TERM_SEL_RESET   = TERM_SEL_7P5;
  localparam logic [1:0] FAST_SEL_RESET   = 2'h0;
  localparam logic [1:0] PRE_LIMIT_RESET  = 2'h1;
  localparam logic [1:0] FAST_LIMIT_RESET = 2'h1;
  localparam logic [7:0] TRICKLE_PCT      = 8'h0A;

  typedef enum logic [3:0] {
    ST_OFF       = 4'h0,
    ST_SHORT     = 4'h1,
    ST_PRE       = 4'h3,
    ST_FAST      = 4'h2,
    ST_CV        = 4'h6,
    ST_DONE      = 4'h7,
    ST_DET_SINK  = 4'h5,
    ST_INS_SRC   = 4'h4,
    ST_FULL_SINK = 4'hC,
    ST_SUSPEND   = 4'hD,
    ST_FAULT     = 4'hF
  } chg_state_t;

  // Comparator decisions from the analog charger.
  typedef struct packed {
    logic vbat_above_short;
    logic vbat_above_lowv;
    logic vbat_at_reg;
    logic vbat_above_rch;
    logic ichg_below_term;
    logic input_limit_loop;
    logic thermal_loop;
    logic power_path_limit;
    logic batt_hot;
    logic batt_cold;
    logic die_shutdown;
    logic usb_valid;
    logic ac_valid;
  } analog_in_t;

  // Host configuration bits.
  typedef struct packed {
    logic       charger_enable;
    logic       term_disable;
    logic       safety_timer_enable;
    logic       dynamic_timer_enable;
    logic       charger_reset;
    logic       temp_window_select;
    logic       thermistor_type_select;
    logic [1:0] term_current_select;
    logic [1:0] fast_charge_current_select;
    logic [1:0] fast_time_select;
    logic [1:0] pre_time_select;
  } chg_cfg_t;

  // Drive requests toward the analog charger and status flags.
  typedef struct packed {
    logic       source_short_test;
    logic       source_trickle;
    logic       source_fast;
    logic       hold_voltage;
    logic       sink_detect;
    logic [7:0] trickle_pct;
    logic [1:0] current_select;
    logic [1:0] term_select;
    logic       temp_window;
    logic       thermistor_type;
  } chg_drive_t;

  typedef struct packed {
    logic termination_reached_flag;
    logic fast_charge_timeout_flag;
    logic precharge_timeout_flag;
    logic battery_temp_error;
    logic temp_fault;
    logic timer_half_rate;
  } chg_status_t;

endpackage

// ### core/chg_sync.sv
// Two flip-flop synchroniser for a bundle of comparator levels.
`timescale 1ns/1ns
module chg_sync #(
  parameter int unsigned WIDTH = 13
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  initial begin
    if (WIDTH < 1) begin
      $error("chg_sync width must be at least one");
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // chg_sync

// ### core/chg_tick.sv
// Prescaler giving the safety-timer tick, with optional half rate.
`timescale 1ns/1ns
module chg_tick #(
  parameter int unsigned DIVIDE = 125000
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Control
  input  wire logic run,
  input  wire logic half_rate,
  // Tick
  output logic      tick
);
  localparam int unsigned CW = $clog2(DIVIDE + 1);
  logic [CW-1:0] div_ff;
  logic          phase_ff;

  initial begin
    if (DIVIDE < 2) begin
      $error("chg_tick divide must be at least two");
    end
  end

  // A frozen prescaler keeps its count, so a pause never loses time.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff   <= '0;
      phase_ff <= 1'b0;
      tick     <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (run) begin
        if (div_ff == CW'(DIVIDE - 1)) begin
          div_ff   <= '0;
          phase_ff <= ~phase_ff;
          tick     <= ~half_rate | phase_ff;
        end else begin
          div_ff <= div_ff + 1'b1;
        end
      end
    end
  end
endmodule // chg_tick

// ### core/chg_seq.sv
// Charge sequencer of a single-cell lithium battery charger.
`timescale 1ns/1ns
module chg_seq
  import chg_seq_pkg::*;
#(
  parameter int unsigned TICK_DIV  = chg_seq_pkg::TICK_CYCLES,
  parameter int unsigned DET_TIME  = chg_seq_pkg::DET_TICKS,
  parameter int unsigned PRE_BASE  = 30 * 60,
  parameter int unsigned FAST_BASE = 60 * 60 * 4
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  // Analog decisions and host configuration
  input  wire chg_seq_pkg::analog_in_t  analog_in,
  input  wire chg_seq_pkg::chg_cfg_t    cfg,
  // Drive and status
  output chg_seq_pkg::chg_drive_t       drive,
  output chg_seq_pkg::chg_status_t      status,
  output chg_seq_pkg::chg_state_t       state_out
);
  import chg_seq_pkg::*;

  initial begin
    if (PRE_BASE * 4 >= (1 << TMR_W) || FAST_BASE * 4 >= (1 << TMR_W)) begin
      $error("chg_seq time limits exceed timer width");
    end
    if (DET_TIME < 1 || DET_TIME >= (1 << TMR_W)) begin
      $error("chg_seq detection time out of range");
    end
  end

  analog_in_t  a;
  chg_state_t  state_ff;
  chg_state_t  nxt_state;
  chg_state_t  resume_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] det_ff;
  logic        usb_d_ff;
  logic        ac_d_ff;
  logic        rst_d_ff;
  logic        restart;
  logic        temp_fault;
  logic        timers_on;
  logic        half_rate;
  logic        tick;
  logic        charging;
  logic        term_ok;
  logic        det_done;
  logic [TMR_W-1:0] pre_limit;
  logic [TMR_W-1:0] fast_limit;

  chg_sync #(
    .WIDTH ($bits(analog_in_t))
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (analog_in),
    .sync_out (a)
  );

  assign temp_fault = a.batt_hot | a.batt_cold | a.die_shutdown;
  assign timers_on  = cfg.safety_timer_enable & ~cfg.term_disable;
  assign half_rate  = cfg.dynamic_timer_enable & (a.input_limit_loop |
                      a.thermal_loop | a.power_path_limit);
  assign charging   = (state_ff == ST_PRE) | (state_ff == ST_FAST) |
                      (state_ff == ST_CV);
  assign term_ok    = a.ichg_below_term & ~a.input_limit_loop &
                      ~a.thermal_loop & ~cfg.term_disable;
  assign det_done   = det_ff == TMR_W'(DET_TIME);
  assign restart    = (a.usb_valid & ~usb_d_ff) | (a.ac_valid & ~ac_d_ff) |
                      (cfg.charger_reset & ~rst_d_ff) |
                      ~a.vbat_above_rch;
  // Host time selects scale a base limit by one to four.
  assign pre_limit  = TMR_W'(PRE_BASE) * ({22'h0, cfg.pre_time_select}
                      + 24'h1);
  assign fast_limit = TMR_W'(FAST_BASE) * ({22'h0, cfg.fast_time_select}
                      + 24'h1);

  chg_tick #(
    .DIVIDE (TICK_DIV)
  ) u_tick (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .run       (charging | (state_ff == ST_DET_SINK) |
                (state_ff == ST_INS_SRC) | (state_ff == ST_FULL_SINK)),
    .half_rate (half_rate & charging),
    .tick      (tick)
  );

  // Edge memories for the USB, AC and host reset restart sources.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      usb_d_ff <= 1'b0;
      ac_d_ff  <= 1'b0;
      rst_d_ff <= 1'b0;
    end else begin
      usb_d_ff <= a.usb_valid;
      ac_d_ff  <= a.ac_valid;
      rst_d_ff <= cfg.charger_reset;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF: begin
        if (cfg.charger_enable) begin
          nxt_state = ST_SHORT;
        end
      end
      ST_SHORT: begin
        if (a.vbat_above_short) begin
          nxt_state = ST_PRE;
        end
      end
      ST_PRE: begin
        if (temp_fault) begin
          nxt_state = ST_SUSPEND;
        end else if (a.vbat_above_lowv) begin
          nxt_state = ST_FAST;
        end else if (timers_on && tmr_ff >= pre_limit) begin
          nxt_state = ST_FAULT;
        end
      end
      ST_FAST: begin
        if (temp_fault) begin
          nxt_state = ST_SUSPEND;
        end else if (a.vbat_at_reg) begin
          nxt_state = ST_CV;
        end else if (timers_on && tmr_ff >= fast_limit) begin
          nxt_state = ST_FAULT;
        end
      end
      ST_CV: begin
        if (temp_fault) begin
          nxt_state = ST_SUSPEND;
        end else if (term_ok) begin
          nxt_state = ST_DONE;
        end else if (timers_on && tmr_ff >= fast_limit) begin
          nxt_state = ST_FAULT;
        end
      end
      ST_SUSPEND: begin
        if (!temp_fault) begin
          nxt_state = resume_ff;
        end
      end
      ST_DONE: begin
        if (!a.vbat_above_rch) begin
          nxt_state = ST_DET_SINK;
        end
      end
      ST_DET_SINK: begin
        if (!a.vbat_above_lowv) begin
          nxt_state = ST_INS_SRC;
        end else if (det_done) begin
          nxt_state = ST_PRE;
        end
      end
      ST_INS_SRC: begin
        if (det_done) begin
          nxt_state = a.vbat_above_rch ? ST_FULL_SINK : ST_PRE;
        end
      end
      ST_FULL_SINK: begin
        if (!a.vbat_above_lowv) begin
          nxt_state = ST_INS_SRC;
        end else if (det_done) begin
          nxt_state = ST_PRE;
        end
      end
      ST_FAULT: begin
        if (restart) begin
          nxt_state = ST_SHORT;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
    if (!cfg.charger_enable) begin
      nxt_state = ST_OFF;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= ST_OFF;
      resume_ff <= ST_PRE;
    end else begin
      state_ff <= nxt_state;
      if (charging) begin
        resume_ff <= state_ff;
      end
    end
  end

  // Safety timer: cleared on entry to precharge or fast charge but not on resume, held while suspended.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_ff <= '0;
    end else if ((state_ff == ST_PRE && nxt_state == ST_FAST) ||
                 (state_ff != ST_PRE && state_ff != ST_SUSPEND &&
                  nxt_state == ST_PRE)) begin
      tmr_ff <= '0;
    end else if (charging && tick && timers_on &&
                 tmr_ff != {TMR_W{1'b1}}) begin
      tmr_ff <= tmr_ff + 1'b1;
    end
  end

  // Detection interval counter, restarted on each detection step.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      det_ff <= '0;
    end else if (nxt_state != state_ff) begin
      det_ff <= '0;
    end else if (tick && !det_done) begin
      det_ff <= det_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status.temp_fault      <= temp_fault;
      status.timer_half_rate <= half_rate & charging;
      if (state_ff == ST_CV && nxt_state == ST_DONE) begin
        status.termination_reached_flag <= 1'b1;
      end else if (nxt_state == ST_PRE) begin
        status.termination_reached_flag <= 1'b0;
      end
      if (state_ff == ST_PRE && nxt_state == ST_FAULT) begin
        status.precharge_timeout_flag <= 1'b1;
      end else if (state_ff == ST_FAULT && restart) begin
        status.precharge_timeout_flag <= 1'b0;
      end
      // Only a fast or constant-voltage phase may raise the fast timeout.
      if ((state_ff == ST_FAST || state_ff == ST_CV) &&
          nxt_state == ST_FAULT) begin
        status.fast_charge_timeout_flag <= 1'b1;
      end else if (state_ff == ST_FAULT && restart) begin
        status.fast_charge_timeout_flag <= 1'b0;
      end
      if (nxt_state == ST_INS_SRC) begin
        status.battery_temp_error <= 1'b1;
      end else if (nxt_state == ST_PRE) begin
        status.battery_temp_error <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drive     <= '0;
      state_out <= ST_OFF;
    end else begin
      state_out               <= nxt_state;
      drive.source_short_test <= nxt_state == ST_SHORT;
      drive.source_trickle    <= nxt_state == ST_PRE ||
                                 nxt_state == ST_INS_SRC;
      drive.source_fast       <= nxt_state == ST_FAST;
      drive.hold_voltage      <= nxt_state == ST_CV;
      drive.sink_detect       <= nxt_state == ST_DET_SINK ||
                                 nxt_state == ST_FULL_SINK;
      drive.trickle_pct       <= TRICKLE_PCT;
      drive.current_select    <= cfg.fast_charge_current_select;
      drive.term_select       <= cfg.term_current_select;
      drive.temp_window       <= cfg.temp_window_select;
      drive.thermistor_type   <= cfg.thermistor_type_select;
    end
  end

  sequence s_cv_term;
    state_ff == ST_CV && cfg.charger_enable && !temp_fault && term_ok;
  endsequence

  AST_TERM_STOPS: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cv_term |=> state_ff == ST_DONE ##1 status.termination_reached_flag
    && !drive.hold_voltage)
    else $error("termination did not stop charger");
  AST_NO_TERM_IN_LOOP: assert property (@(posedge core_clk)
    disable iff (!nrst) (state_ff == ST_CV && (a.thermal_loop ||
    a.input_limit_loop)) |=> state_ff != ST_DONE)
    else $error("termination while regulation loop active");
  AST_PRE_TO_FAST: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_ff == ST_PRE && cfg.charger_enable && !temp_fault &&
    a.vbat_above_lowv) |=> state_ff == ST_FAST && drive.source_fast)
    else $error("precharge did not move to fast charge");
  AST_TIMER_FROZEN: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_ff == ST_SUSPEND && nxt_state == ST_SUSPEND) |=>
    $stable(tmr_ff))
    else $error("safety timer moved while suspended");
  AST_TIMER_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
    (!timers_on && $past(!timers_on) && charging) |->
    tmr_ff <= $past(tmr_ff))
    else $error("timer advanced while disabled");
  AST_SHORT_FIRST: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_ff == ST_OFF && nxt_state != ST_OFF) |=> state_ff == ST_SHORT)
    else $error("charging began without short test");
  AST_FAULT_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_ff == ST_FAULT && restart && cfg.charger_enable) |=>
    !status.precharge_timeout_flag && !status.fast_charge_timeout_flag)
    else $error("timeout flags not cleared on restart");
  AST_REMOVAL_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_ff == ST_DET_SINK && cfg.charger_enable && !a.vbat_above_lowv)
    |=> status.battery_temp_error)
    else $error("removal did not flag battery temperature");
endmodule // chg_seq

// ### testbench/chg_host_model.sv
// Host model holding the charger configuration bits with reset defaults.
`timescale 1ns/1ns
module chg_host_model
  import chg_seq_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // Write request
  input  wire logic                  wr_en,
  input  wire chg_seq_pkg::chg_cfg_t wr_data,
  // Configuration toward the sequencer
  output chg_seq_pkg::chg_cfg_t      cfg
);
  import chg_seq_pkg::*;

  // A register bank loses its contents in reset, so defaults come back.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg                            <= '0;
      cfg.safety_timer_enable        <= 1'b1;
      cfg.dynamic_timer_enable       <= 1'b1;
      cfg.term_current_select        <= TERM_SEL_RESET;
      cfg.fast_charge_current_select <= FAST_SEL_RESET;
      cfg.fast_time_select           <= FAST_LIMIT_RESET;
      cfg.pre_time_select            <= PRE_LIMIT_RESET;
    end else if (wr_en) begin
      cfg <= wr_data;
    end
  end
endmodule // chg_host_model

// ### testbench/test_chg_seq.sv
// Self-checking testbench of the charge sequencer.
`timescale 1ns/1ns
module test_chg_seq;
  import chg_seq_pkg::*;

  logic        core_clk;
  logic        nrst;
  logic        wr_en;
  chg_cfg_t    wr_data;
  chg_cfg_t    cfg;
  chg_cfg_t    c;
  analog_in_t  ana;
  chg_drive_t  drive;
  chg_status_t status;
  chg_state_t  state_out;
  int          fails;
  int          cmp_count;

  chg_host_model i_host (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr_en    (wr_en),
    .wr_data  (wr_data),
    .cfg      (cfg)
  );

  // Short counts keep the run brief; limits scale from these values.
  chg_seq #(
    .TICK_DIV  (4),
    .DET_TIME  (3),
    .PRE_BASE  (10),
    .FAST_BASE (20)
  ) i_dut (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .analog_in (ana),
    .cfg       (cfg),
    .drive     (drive),
    .status    (status),
    .state_out (state_out)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic write_cfg();
    @(posedge core_clk);
    wr_en   <= 1'b1;
    wr_data <= c;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Waits for a state; a wait that runs out counts as a mismatch.
  task automatic wait_state(input chg_state_t s, input int limit);
    int i;
    for (i = 0; i < limit; i++) begin
      @(posedge core_clk);
      #1;
      if (state_out === s) begin
        break;
      end
    end
    check_val({4'h0, state_out}, {4'h0, s});
    if (state_out !== s) begin
      conclude();
    end
  endtask

  initial begin
    nrst    = 1'b0;
    wr_en   = 1'b0;
    ana     = '0;
    c       = '0;
    c.safety_timer_enable  = 1'b1;
    c.dynamic_timer_enable = 1'b1;
    c.term_current_select  = TERM_SEL_RESET;
    c.fast_time_select     = FAST_LIMIT_RESET;
    c.pre_time_select      = PRE_LIMIT_RESET;
    wr_data = c;
    fails   = 0;
    cmp_count = 0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    cycles(2);
    check_bit(cfg.safety_timer_enable, 1'b1);
    check_bit(cfg.dynamic_timer_enable, 1'b1);
    check_val({6'h00, drive.term_select}, {6'h00, TERM_SEL_7P5});
    check_val({4'h0, state_out}, {4'h0, ST_OFF});

    // Full charge walk with a suspension and suppressed termination.
    c.charger_enable = 1'b1;
    write_cfg();
    wait_state(ST_SHORT, 10);
    check_bit(drive.source_short_test, 1'b1);
    check_bit(drive.source_trickle, 1'b0);
    @(posedge core_clk);
    ana.vbat_above_short <= 1'b1;
    wait_state(ST_PRE, 10);
    check_bit(drive.source_trickle, 1'b1);
    check_val(drive.trickle_pct, 8'h0A);
    @(posedge core_clk);
    ana.vbat_above_lowv <= 1'b1;
    ana.vbat_above_rch  <= 1'b1;
    wait_state(ST_FAST, 10);
    check_bit(drive.source_fast, 1'b1);
    @(posedge core_clk);
    ana.batt_cold <= 1'b1;
    wait_state(ST_SUSPEND, 10);
    check_bit(status.temp_fault, 1'b1);
    check_bit(drive.source_fast, 1'b0);
    @(posedge core_clk);
    ana.batt_cold <= 1'b0;
    wait_state(ST_FAST, 10);
    @(posedge core_clk);
    ana.vbat_at_reg <= 1'b1;
    wait_state(ST_CV, 10);
    check_bit(drive.hold_voltage, 1'b1);
    @(posedge core_clk);
    ana.thermal_loop    <= 1'b1;
    ana.ichg_below_term <= 1'b1;
    cycles(6);
    check_val({4'h0, state_out}, {4'h0, ST_CV});
    check_bit(status.timer_half_rate, 1'b1);
    @(posedge core_clk);
    ana.thermal_loop <= 1'b0;
    wait_state(ST_DONE, 10);
    check_bit(status.termination_reached_flag, 1'b1);
    check_bit(drive.hold_voltage, 1'b0);
    $display("test walk done");

    // Recharge drop with the battery still present restarts charging.
    @(posedge core_clk);
    ana.vbat_above_rch <= 1'b0;
    wait_state(ST_DET_SINK, 10);
    check_bit(drive.sink_detect, 1'b1);
    wait_state(ST_PRE, 100);
    $display("test recharge done");

    // A removed battery is sought by sourcing, then by a second sink test.
    wait_state(ST_DET_SINK, 40);
    @(posedge core_clk);
    ana.vbat_above_lowv <= 1'b0;
    wait_state(ST_INS_SRC, 10);
    check_bit(status.battery_temp_error, 1'b1);
    check_bit(drive.source_trickle, 1'b1);
    @(posedge core_clk);
    ana.vbat_above_rch <= 1'b1;
    wait_state(ST_FULL_SINK, 40);
    check_bit(drive.sink_detect, 1'b1);
    wait_state(ST_INS_SRC, 10);
    @(posedge core_clk);
    ana.vbat_above_rch <= 1'b0;
    wait_state(ST_PRE, 40);
    $display("test removal done");

    // Precharge that never passes the entry voltage times out.
    c.charger_enable = 1'b0;
    write_cfg();
    wait_state(ST_OFF, 10);
    @(posedge core_clk);
    ana.vbat_above_lowv <= 1'b0;
    ana.vbat_above_rch  <= 1'b1;
    ana.vbat_at_reg     <= 1'b0;
    ana.ichg_below_term <= 1'b0;
    cycles(4);
    c.charger_enable = 1'b1;
    write_cfg();
    wait_state(ST_PRE, 20);
    wait_state(ST_FAULT, 600);
    cycles(2);
    check_bit(status.precharge_timeout_flag, 1'b1);
    check_bit(status.fast_charge_timeout_flag, 1'b0);
    c.charger_reset = 1'b1;
    write_cfg();
    wait_state(ST_SHORT, 10);
    check_bit(status.precharge_timeout_flag, 1'b0);
    c.charger_reset = 1'b0;
    write_cfg();
    @(posedge core_clk);
    ana.vbat_above_lowv <= 1'b1;
    wait_state(ST_FAST, 10);
    wait_state(ST_FAULT, 300);
    check_bit(status.fast_charge_timeout_flag, 1'b1);
    check_bit(status.precharge_timeout_flag, 1'b0);
    @(posedge core_clk);
    ana.vbat_above_rch <= 1'b0;
    wait_state(ST_SHORT, 10);
    check_bit(status.fast_charge_timeout_flag, 1'b0);
    $display("test timeout done");

    // With termination disabled the charger holds voltage and never times out.
    c.term_disable = 1'b1;
    write_cfg();
    @(posedge core_clk);
    ana.vbat_above_lowv <= 1'b1;
    ana.vbat_at_reg     <= 1'b1;
    ana.ichg_below_term <= 1'b1;
    wait_state(ST_CV, 40);
    cycles(500);
    check_val({4'h0, state_out}, {4'h0, ST_CV});
    check_bit(status.fast_charge_timeout_flag, 1'b0);
    $display("test term disable done");

    // Configuration fields reach the drive outputs unchanged.
    for (int k = 0; k < 4; k++) begin
      c.term_current_select    = 2'(k);
      c.temp_window_select     = k[0];
      c.thermistor_type_select = k[1];
      c.fast_charge_current_select = 2'(3 - k);
      write_cfg();
      cycles(2);
      check_val({6'h00, drive.term_select}, 8'(k));
      check_val({6'h00, drive.current_select}, 8'(3 - k));
      check_bit(drive.temp_window, k[0]);
      check_bit(drive.thermistor_type, k[1]);
    end

    // Disabling the charger forces it off from any state.
    c.charger_enable = 1'b0;
    write_cfg();
    wait_state(ST_OFF, 10);
    check_bit(drive.hold_voltage, 1'b0);
    $display("test config done");
    conclude();
  end

  initial begin
    #400_000;
    fails++;
    conclude();
  end
endmodule // test_chg_seq
